//--- pkg/io_card_pkg.sv
// Summary of operation
// - While clock_enable is high, the extended-map indicator is lit exactly while 64 Kbyte extended addressing is selected.
// - While clock_enable is high, the wide-path indicator is lit whenever the path width jumper selects a 16-bit data path.
// - While clock_enable is high, the narrow-path indicator is lit in 8-bit mode, so one path indicator is lit.
// - Each of the sixteen output indicators is lit exactly while its transistor conducts.
// - While clock_enable is high, each of the sixteen input indicators is lit exactly while its input contact is closed.
// - With the fetch-select jumper fitted the opcode-fetch signal takes part in decoding.
// - With the reset-link jumper fitted the bus reset reaches the reset logic, else it does not.
// - Mapping jumper removed gives 256-byte addressing, fitted gives 64 Kbyte addressing.
// - The bus data path is 8 or 16 bits wide as the path width jumper selects.
// - While clock_enable is high and bus reset is linked and asserted, all outputs are held disabled.
// - All outputs are disabled at every power-on, whether bus reset is linked or not.
// - The card occupies two consecutive bytes, or one word in 16-bit mode, at a chosen base.
// - Normal mode compares only the low switch bank; extended mode also compares the high bank.
package io_card_pkg;

  localparam logic       OFF_GROUP_A  = 1'h0;
  localparam logic       OFF_GROUP_B  = 1'h1;
  localparam int         LOW_CMP_LSB  = 1;
  localparam int         LOW_CMP_MSB  = 7;
  localparam int         HIGH_CMP_LSB = 8;
  localparam int         HIGH_CMP_MSB = 15;
  localparam logic [7:0] OUT_RESET    = 8'h00;
  localparam logic [7:0] IN_RESET     = 8'hFF;
  localparam logic [7:0] DATA_IDLE    = 8'h00;

  // Backplane signals sampled by the card, all driven by the bus master.
  typedef struct packed {
    logic [15:0] addr;
    logic        io_request_n;
    logic        opcode_fetch_cycle_n;
    logic        lower_byte_read_strobe_n;
    logic        lower_byte_write_strobe_n;
    logic        upper_byte_read_strobe_n;
    logic        upper_byte_write_strobe_n;
    logic        bus_reset_n;
  } bus_cycle_t;

  // A fitted jumper reads as one; path width one means position 2-3.
  typedef struct packed {
    logic fetch_select_jumper;
    logic reset_link_jumper;
    logic mapping_size_jumper;
    logic path_width_jumper;
  } jumper_cfg_t;

endpackage : io_card_pkg

//--- rtl/io_card_bus_config.sv
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module io_card_bus_config (
  input  wire logic                     clock,
  input  wire logic                     reset_n,
  input  wire logic                     clock_enable,
  input  wire io_card_pkg::bus_cycle_t  bus,
  input  wire io_card_pkg::jumper_cfg_t jumpers,
  input  wire logic [7:0]               low_base_switches,
  input  wire logic [7:0]               high_base_switches,
  input  wire logic [15:0]              data_in,
  input  wire logic [7:0]               input_group_a,
  input  wire logic [7:0]               input_group_b,
  output logic [15:0]                   data_out,
  output logic [1:0]                    data_oe,
  output logic [7:0]                    output_group_a,
  output logic [7:0]                    output_group_b,
  output logic                          extended_map_indicator,
  output logic                          wide_path_indicator,
  output logic                          narrow_path_indicator,
  output logic [7:0]                    out_group_a_indicators,
  output logic [7:0]                    out_group_b_indicators,
  output logic [7:0]                    in_group_a_indicators,
  output logic [7:0]                    in_group_b_indicators
);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release and bus sampling.

  logic                   rst_meta_r;
  logic                   rst_sync_n_r;
  io_card_pkg::bus_cycle_t bus_r;
  logic                   lw_prev_r;
  logic                   uw_prev_r;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r   <= 1'b0;
      rst_sync_n_r <= 1'b0;
    end else begin
      rst_meta_r   <= 1'b1;
      rst_sync_n_r <= rst_meta_r;
    end
  end

  // The card only samples the master's signals and never drives them.
  always_ff @(posedge clock or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      bus_r     <= '1;
      lw_prev_r <= 1'b1;
      uw_prev_r <= 1'b1;
    end else if (clock_enable) begin
      bus_r     <= bus;
      lw_prev_r <= bus_r.lower_byte_write_strobe_n;
      uw_prev_r <= bus_r.upper_byte_write_strobe_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode.

  logic cycle_ok;
  logic low_hit;
  logic high_hit;
  logic selected;
  logic wide;
  logic lw_fall;
  logic uw_fall;
  logic wr_a;
  logic wr_b;
  logic rd_low;
  logic rd_high;
  logic bus_reset_hit;

  always_comb begin
    // With the fetch-select jumper fitted, a request during an opcode fetch is an acknowledge cycle, not ours.
    cycle_ok = !bus_r.io_request_n &&
               (!jumpers.fetch_select_jumper || bus_r.opcode_fetch_cycle_n);
    // Switches read low when fitted, matching the address bit directly.
    low_hit  = bus_r.addr[io_card_pkg::LOW_CMP_MSB:io_card_pkg::LOW_CMP_LSB] ==
               low_base_switches[io_card_pkg::LOW_CMP_MSB:io_card_pkg::LOW_CMP_LSB];
    // High bank matters only with extended mapping.
    high_hit = !jumpers.mapping_size_jumper ||
               (bus_r.addr[io_card_pkg::HIGH_CMP_MSB:io_card_pkg::HIGH_CMP_LSB] ==
                high_base_switches);
    selected = cycle_ok && low_hit && high_hit;
    wide     = jumpers.path_width_jumper;
    lw_fall  = lw_prev_r && !bus_r.lower_byte_write_strobe_n;
    uw_fall  = uw_prev_r && !bus_r.upper_byte_write_strobe_n;
    // In 16-bit mode the word sits at the even address, upper strobe for group B.
    if (wide) begin
      wr_a    = selected && lw_fall && (bus_r.addr[0] == io_card_pkg::OFF_GROUP_A);
      wr_b    = selected && uw_fall && (bus_r.addr[0] == io_card_pkg::OFF_GROUP_A);
      rd_low  = selected && !bus_r.lower_byte_read_strobe_n &&
                (bus_r.addr[0] == io_card_pkg::OFF_GROUP_A);
      rd_high = selected && !bus_r.upper_byte_read_strobe_n &&
                (bus_r.addr[0] == io_card_pkg::OFF_GROUP_A);
    end else begin
      wr_a    = selected && lw_fall && (bus_r.addr[0] == io_card_pkg::OFF_GROUP_A);
      wr_b    = selected && lw_fall && (bus_r.addr[0] == io_card_pkg::OFF_GROUP_B);
      rd_low  = selected && !bus_r.lower_byte_read_strobe_n;
      rd_high = 1'b0;
    end
    // Bus reset only counts while the link jumper is fitted.
    bus_reset_hit = jumpers.reset_link_jumper && !bus_r.bus_reset_n;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output transistors and their indicators.

  logic [7:0] out_a_nxt;
  logic [7:0] out_b_nxt;

  always_comb begin
    out_a_nxt = output_group_a;
    out_b_nxt = output_group_b;
    if (bus_reset_hit) begin
      out_a_nxt = io_card_pkg::OUT_RESET;
      out_b_nxt = io_card_pkg::OUT_RESET;
    end else begin
      if (wr_a) begin
        out_a_nxt = data_in[7:0];
      end
      if (wr_b) begin
        out_b_nxt = wide ? data_in[15:8] : data_in[7:0];
      end
    end
  end

  // Power-on always clears the outputs through the internal reset.
  always_ff @(posedge clock or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      output_group_a         <= io_card_pkg::OUT_RESET;
      output_group_b         <= io_card_pkg::OUT_RESET;
      out_group_a_indicators <= io_card_pkg::OUT_RESET;
      out_group_b_indicators <= io_card_pkg::OUT_RESET;
    end else if (clock_enable) begin
      output_group_a         <= out_a_nxt;
      output_group_b         <= out_b_nxt;
      out_group_a_indicators <= out_a_nxt;
      out_group_b_indicators <= out_b_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Inputs, read data and configuration indicators.

  logic [7:0] in_a_r;
  logic [7:0] in_b_r;

  // An open contact reads one, a closed contact reads zero and lights its lamp.
  always_ff @(posedge clock or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      in_a_r                <= io_card_pkg::IN_RESET;
      in_b_r                <= io_card_pkg::IN_RESET;
      in_group_a_indicators <= ~io_card_pkg::IN_RESET;
      in_group_b_indicators <= ~io_card_pkg::IN_RESET;
    end else if (clock_enable) begin
      in_a_r                <= input_group_a;
      in_b_r                <= input_group_b;
      in_group_a_indicators <= ~input_group_a;
      in_group_b_indicators <= ~input_group_b;
    end
  end

  // The data bus is driven only during a read that hits our window.
  always_ff @(posedge clock or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      data_oe  <= 2'h0;
      data_out <= {io_card_pkg::DATA_IDLE, io_card_pkg::DATA_IDLE};
    end else if (clock_enable) begin
      data_oe       <= {rd_high, rd_low};
      data_out[7:0] <= !rd_low ? io_card_pkg::DATA_IDLE :
                       (!wide && bus_r.addr[0] == io_card_pkg::OFF_GROUP_B) ? in_b_r : in_a_r;
      data_out[15:8] <= rd_high ? in_b_r : io_card_pkg::DATA_IDLE;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      extended_map_indicator <= 1'b0;
      wide_path_indicator    <= 1'b0;
      narrow_path_indicator  <= 1'b0;
    end else if (clock_enable) begin
      extended_map_indicator <= jumpers.mapping_size_jumper;
      wide_path_indicator    <= jumpers.path_width_jumper;
      narrow_path_indicator  <= !jumpers.path_width_jumper;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_n_r);

  AST_EXT_LAMP: assert property (clock_enable |=>
    extended_map_indicator == $past(jumpers.mapping_size_jumper))
    else $error("Extended map lamp does not follow the mapping jumper.");

  AST_WIDE_LAMP: assert property (clock_enable |=>
    wide_path_indicator == $past(jumpers.path_width_jumper))
    else $error("Wide path lamp does not follow the width jumper.");

  AST_ONE_PATH_LAMP: assert property (clock_enable |=>
    (wide_path_indicator ^ narrow_path_indicator))
    else $error("Exactly one path lamp must be lit.");

  AST_OUT_LAMPS: assert property (
    out_group_a_indicators == output_group_a && out_group_b_indicators == output_group_b)
    else $error("Output lamps differ from output state.");

  AST_IN_LAMPS: assert property (clock_enable |=>
    in_group_a_indicators == ~$past(input_group_a) &&
    in_group_b_indicators == ~$past(input_group_b))
    else $error("Input lamps do not show closed contacts.");

  AST_FETCH_BLOCK: assert property (
    jumpers.fetch_select_jumper && !bus_r.opcode_fetch_cycle_n |-> !selected)
    else $error("Card selected during an opcode fetch cycle.");

  AST_BUS_RESET: assert property (clock_enable && jumpers.reset_link_jumper &&
    !bus_r.bus_reset_n |=> output_group_a == 8'h00 && output_group_b == 8'h00)
    else $error("Outputs not cleared by linked bus reset.");

  AST_RESET_UNLINKED: assert property (clock_enable && !jumpers.reset_link_jumper &&
    !wr_a && !wr_b |=> output_group_a == $past(output_group_a) &&
    output_group_b == $past(output_group_b))
    else $error("Unlinked bus reset changed the outputs.");

  AST_NORMAL_MAP: assert property (clock_enable && !jumpers.mapping_size_jumper &&
    wr_a |=> output_group_a == $past(data_in[7:0]))
    else $error("Normal mapping write to group A lost.");

  AST_QUIET_BUS: assert property (clock_enable && !selected |=> data_oe == 2'h0)
    else $error("Data bus driven outside the window.");

  COV_WRITE_A: cover property (wr_a);
  COV_WORD_READ: cover property (rd_low && rd_high);
  COV_LINKED_RESET: cover property (bus_reset_hit && output_group_a != 8'h00);
  COV_EXT_HIT: cover property (jumpers.mapping_size_jumper && selected);

endmodule : io_card_bus_config

//--- verif/host_bus_model.sv
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic                    clock,
  input  wire logic [15:0]             data_out,
  input  wire logic [1:0]              data_oe,
  output io_card_pkg::bus_cycle_t      bus,
  output logic [15:0]                  data_in
);
  logic [15:0] wdata_r = 16'h0000;
  logic [1:0]  drive_r = 2'h0;
  logic [15:0] last_r  = 16'h0000;
  ////////////////////////////////////////////////////////////////////////////////
  // A lane that nobody drives shows the inverse of its last value, never a stale copy.
  for (genvar i = 0; i < 2; i++) begin : g_lane
    assign data_in[i*8 +: 8] = drive_r[i] ? wdata_r[i*8 +: 8]
                             : data_oe[i] ? data_out[i*8 +: 8] : ~last_r[i*8 +: 8];
  end
  always_ff @(posedge clock) last_r <= data_in;
  initial bus = '1;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic access(input logic [15:0] a, input logic wr, input logic [1:0] lanes,
                        input logic fetch_n, input logic [15:0] d,
                        output logic [15:0] q, output logic [1:0] oe);
    @(posedge clock);
    bus <= '{addr: a, io_request_n: 1'b0, opcode_fetch_cycle_n: fetch_n,
             lower_byte_read_strobe_n: wr | ~lanes[0], lower_byte_write_strobe_n: ~wr | ~lanes[0],
             upper_byte_read_strobe_n: wr | ~lanes[1], upper_byte_write_strobe_n: ~wr | ~lanes[1],
             bus_reset_n: bus.bus_reset_n};
    drive_r <= wr ? lanes : 2'h0;
    wdata_r <= d;
    repeat (4) @(posedge clock);
    q = data_in;
    oe = data_oe;
    bus <= '{addr: a, bus_reset_n: bus.bus_reset_n, default: 1'b1};
    drive_r <= 2'h0;
    repeat (3) @(posedge clock);
  endtask : access
  task automatic set_bus_reset(input logic level_n);
    @(posedge clock);
    bus.bus_reset_n <= level_n;
  endtask : set_bus_reset
endmodule : host_bus_model

//--- verif/tb.sv
`timescale 1ns/1ps
module tb;
  localparam logic [7:0]  LOW_SW  = 8'h4A;
  localparam logic [7:0]  HIGH_SW = 8'h14;
  localparam logic [15:0] BASE    = {HIGH_SW, LOW_SW[7:1], 1'b0};
  logic                     clock;
  logic                     reset_n;
  io_card_pkg::bus_cycle_t  bus;
  io_card_pkg::jumper_cfg_t jumpers;
  logic [15:0]              data_in, data_out, q;
  logic [1:0]               data_oe, oe;
  logic [7:0]               in_a, in_b, out_a, out_b, oa_ind, ob_ind, ia_ind, ib_ind;
  logic                     ext_ind, wide_ind, narrow_ind;
  logic                     clk_en;
  int                       n_fail, total_checks, cycles;
  ////////////////////////////////////////////////////////////////////////////////
  io_card_bus_config dut (.clock(clock), .reset_n(reset_n), .clock_enable(clk_en), .bus(bus),
    .jumpers(jumpers), .low_base_switches(LOW_SW), .high_base_switches(HIGH_SW),
    .data_in(data_in), .input_group_a(in_a), .input_group_b(in_b), .data_out(data_out),
    .data_oe(data_oe), .output_group_a(out_a), .output_group_b(out_b),
    .extended_map_indicator(ext_ind), .wide_path_indicator(wide_ind),
    .narrow_path_indicator(narrow_ind), .out_group_a_indicators(oa_ind),
    .out_group_b_indicators(ob_ind), .in_group_a_indicators(ia_ind),
    .in_group_b_indicators(ib_ind));
  host_bus_model host (.clock(clock), .data_out(data_out), .data_oe(data_oe), .bus(bus),
    .data_in(data_in));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_out(input logic [15:0] exp);
    chk("outputs", exp, {out_b, out_a});
    chk("output indicators", exp, {ob_ind, oa_ind});
  endtask : chk_out
  task automatic wr(input logic [15:0] a, input logic [1:0] lanes, input logic fetch_n,
                    input logic [15:0] d);
    host.access(a, 1'b1, lanes, fetch_n, d, q, oe);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [1:0] lanes);
    host.access(a, 1'b0, lanes, 1'b1, 16'h0000, q, oe);
  endtask : rd
  // Ends on a falling edge so that every registered output has settled when it is compared.
  task automatic settle();
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask : settle
  // Jumper order is fetch select, reset link, mapping size, path width.
  task automatic set_jumpers(input logic [3:0] j);
    @(posedge clock);
    jumpers <= j;
    settle();
  endtask : set_jumpers
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    n_fail = 0;
    total_checks = 0;
    clk_en = 1'b1;
    reset_n = 1'b0;
    jumpers = 4'hE;
    in_a = 8'hFF;
    in_b = 8'hFF;
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    settle();
    chk_out(16'h0000);
    chk("path indicators", 16'h0005, {13'h0000, ext_ind, wide_ind, narrow_ind});
    $display("test reset done");
    wr(BASE, 2'h1, 1'b1, 16'h00A5);
    wr(BASE | 16'h0001, 2'h1, 1'b1, 16'h005A);
    chk_out(16'h5AA5);
    wr(BASE ^ 16'h0100, 2'h1, 1'b1, 16'h00FF);
    wr(BASE, 2'h1, 1'b0, 16'h00FF);
    chk_out(16'h5AA5);
    $display("test write done");
    @(posedge clock);
    in_a <= 8'h3C;
    in_b <= 8'hC3;
    settle();
    chk("input indicators", 16'h3CC3, {ib_ind, ia_ind});
    rd(BASE, 2'h1);
    chk("read a", 16'h013C, {6'h00, oe, q[7:0]});
    rd(BASE | 16'h0001, 2'h1);
    chk("read b", 16'h01C3, {6'h00, oe, q[7:0]});
    rd(BASE ^ 16'h0100, 2'h1);
    chk("miss enable", 16'h0000, {14'h0000, oe});
    $display("test read done");
    set_jumpers(4'h6);
    wr(BASE, 2'h1, 1'b0, 16'h000F);
    chk_out(16'h5A0F);
    set_jumpers(4'h4);
    chk("map indicator", 16'h0000, {15'h0000, ext_ind});
    wr(BASE ^ 16'hFF00, 2'h1, 1'b1, 16'h0033);
    chk_out(16'h5A33);
    $display("test modes done");
    set_jumpers(4'h7);
    chk("path indicators", 16'h0006, {13'h0000, ext_ind, wide_ind, narrow_ind});
    wr(BASE, 2'h3, 1'b1, 16'h6699);
    wr(BASE | 16'h0001, 2'h1, 1'b1, 16'h0000);
    chk_out(16'h6699);
    rd(BASE, 2'h3);
    chk("word read", 16'hC33C, q);
    chk("word enable", 16'h0003, {14'h0000, oe});
    $display("test wide done");
    @(posedge clock);
    clk_en <= 1'b0;
    in_a <= 8'h00;
    settle();
    chk("frozen input indicators", 16'h3CC3, {ib_ind, ia_ind});
    @(posedge clock);
    clk_en <= 1'b1;
    settle();
    chk("input indicators", 16'h3CFF, {ib_ind, ia_ind});
    $display("test freeze done");
    host.set_bus_reset(1'b0);
    settle();
    chk_out(16'h0000);
    wr(BASE, 2'h3, 1'b1, 16'hFFFF);
    chk_out(16'h0000);
    host.set_bus_reset(1'b1);
    wr(BASE, 2'h3, 1'b1, 16'h1234);
    set_jumpers(4'h3);
    host.set_bus_reset(1'b0);
    settle();
    chk_out(16'h1234);
    host.set_bus_reset(1'b1);
    @(posedge clock);
    reset_n <= 1'b0;
    settle();
    chk_out(16'h0000);
    @(posedge clock);
    reset_n <= 1'b1;
    settle();
    chk("path indicators", 16'h0006, {13'h0000, ext_ind, wide_ind, narrow_ind});
    $display("test resets done");
    close_out();
  end
endmodule : tb
